// >>> hdl/gpio_pin_output_mux.sv
// Functional notes
// - Source field bits 4:2 picks group.
// - Select bits 7:5 meaning depends on source.
// - Port select 000/001/011 give remote pins.
// - Port select 100 lock, 101 pass.
// - Port select 110 frame, 111 line valid.
// - Status select 001 ANDs enabled locks.
// - Status select 011 ANDs enabled passes.
// - Transmit 000 AND, 001 OR selected passes.
// - Transmit 011 gives line valid.
// - Transmit 100 gives synchronized indication.
// - Transmit 101 gives transmit interrupt.
// - Bit 1 holds the local value.
// - Bit 0 enables the output driver.
// - Control at 0x14, read/write, resets 0x00.
// - Status select 000 gives local value.
// - Transmit 010 gives frame valid.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_output_mux
  import pin_mux_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire rx_status_t [PORTS-1:0] rx_status,
  input wire tx_status_t tx_status,
  output logic general_pin_4_out,
  output logic general_pin_4_oe_n
);

  logic [7:0] pin4_output_control;
  logic wr_pending;
  logic rd_pending;
  logic hit_pending;

  wire logic access = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  wire logic addr_hit = (haddr[7:0] == PIN4_CTRL_ADDR) && (haddr[31:8] == 24'h000000);
  wire logic [2:0] pin4_signal_select = pin4_output_control[SEL_HI:SEL_LO];
  wire logic [2:0] pin4_source_group = pin4_output_control[SRC_HI:SRC_LO];
  wire logic pin4_local_value = pin4_output_control[VAL_BIT];
  wire logic pin4_drive_enable = pin4_output_control[EN_BIT];

  // Device-wide reductions over receive ports.
  logic all_lock;
  logic all_pass;
  logic any_lock;
  logic sel_pass_and;
  logic sel_pass_or;
  always_comb begin
    all_lock = 1'b1;
    all_pass = 1'b1;
    any_lock = 1'b0;
    sel_pass_and = 1'b1;
    sel_pass_or = 1'b0;
    for (int i = 0; i < PORTS; i++) begin
      if (rx_status[i].enabled) begin
        all_lock = all_lock & rx_status[i].lock;
        all_pass = all_pass & rx_status[i].pass;
        any_lock = any_lock | rx_status[i].lock;
      end
      if (rx_status[i].selected) begin
        sel_pass_and = sel_pass_and & rx_status[i].pass;
        sel_pass_or = sel_pass_or | rx_status[i].pass;
      end
    end
  end

  // Receive port group: source codes 000..011 index the port.
  wire rx_status_t port_sel = rx_status[pin4_source_group[1:0]];
  logic port_value;
  always_comb begin
    unique case (pin4_signal_select)
      SEL_0: port_value = port_sel.remote_pins[0];
      SEL_1: port_value = port_sel.remote_pins[2];
      SEL_2: port_value = 1'b0;
      SEL_3: port_value = port_sel.remote_pins[3];
      SEL_4: port_value = port_sel.lock;
      SEL_5: port_value = port_sel.pass;
      SEL_6: port_value = port_sel.frame_valid;
      SEL_7: port_value = port_sel.line_valid;
    endcase
  end

  logic status_value;
  always_comb begin
    unique case (pin4_signal_select)
      SEL_0: status_value = pin4_local_value;
      SEL_1: status_value = all_lock;
      SEL_2: status_value = any_lock;
      SEL_3: status_value = all_pass;
      default: status_value = 1'b0;
    endcase
  end

  logic tx_value;
  always_comb begin
    unique case (pin4_signal_select)
      SEL_0: tx_value = sel_pass_and;
      SEL_1: tx_value = sel_pass_or;
      SEL_2: tx_value = tx_status.frame_valid;
      SEL_3: tx_value = tx_status.line_valid;
      SEL_4: tx_value = tx_status.synchronized;
      SEL_5: tx_value = tx_status.irq;
      default: tx_value = 1'b0;
    endcase
  end

  // Reserved source codes drive a quiet low rather than an undefined level.
  wire logic mux_value = !pin4_source_group[2] ? port_value :
                         (pin4_source_group == SRC_STATUS) ? status_value :
                         (pin4_source_group == SRC_TX) ? tx_value : 1'b0;
  wire logic next_pin_out = pin4_drive_enable ? mux_value : 1'b0;
  wire logic next_oe_n = !pin4_drive_enable;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      hit_pending <= 1'b0;
    end else if (clk_en) begin
      wr_pending <= access && hwrite;
      rd_pending <= access && !hwrite;
      hit_pending <= access && addr_hit;
    end
  end

  // Register writes land in the data phase, one cycle after the address phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin4_output_control <= PIN4_CTRL_RESET;
    end else if (clk_en && wr_pending && hit_pending) begin
      pin4_output_control <= hwdata[7:0];
    end
  end

  // A read whose address phase meets a write's data phase must see the byte being written.
  wire logic [7:0] ctl_visible = (wr_pending && hit_pending) ? hwdata[7:0] : pin4_output_control;

  // Read data is registered so it stands for the whole data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (clk_en && access && !hwrite) begin
      hrdata <= addr_hit ? {24'h000000, ctl_visible} : 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // The pin is registered so it cannot glitch while the mux inputs settle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      general_pin_4_out <= 1'b0;
      general_pin_4_oe_n <= 1'b1;
    end else if (clk_en) begin
      general_pin_4_out <= next_pin_out;
      general_pin_4_oe_n <= next_oe_n;
    end
  end

  AST_RESET_VALUE: assert property (@(posedge hclk)
    $rose(hresetn) |-> pin4_output_control == PIN4_CTRL_RESET)
    else $error("control register not at reset value");

  // A register access takes two steps: the address phase, then the data phase edge.
  sequence seq_write_addr;
    clk_en && access && hwrite && addr_hit;
  endsequence

  sequence seq_read_addr;
    clk_en && access && !hwrite && addr_hit;
  endsequence

  sequence seq_data_edge;
    clk_en;
  endsequence

  AST_WRITE_LANDS: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_write_addr ##1 seq_data_edge |=> pin4_output_control == $past(hwdata[7:0]))
    else $error("write did not reach control register");

  AST_READ_BACK: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_read_addr |=> hrdata[7:0] == pin4_output_control && hrdata[31:8] == 24'h000000)
    else $error("read data mismatch");

  AST_DISABLED_NO_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !pin4_drive_enable |=> general_pin_4_oe_n && !general_pin_4_out)
    else $error("pin driven while disabled");

  AST_ENABLED_DRIVES: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable |=> !general_pin_4_oe_n)
    else $error("pin not driven while enabled");

  AST_LOCAL_VALUE: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && pin4_source_group == SRC_STATUS && pin4_signal_select == SEL_0
      |=> general_pin_4_out == $past(pin4_local_value))
    else $error("local value not on pin");

  AST_TX_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && pin4_source_group == SRC_TX && pin4_signal_select == SEL_5
      |=> general_pin_4_out == $past(tx_status.irq))
    else $error("transmit interrupt not on pin");

  AST_PORT_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && !pin4_source_group[2] && pin4_signal_select == SEL_4
      |=> general_pin_4_out == $past(port_sel.lock))
    else $error("port lock not on pin");

  AST_ALL_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && pin4_source_group == SRC_STATUS && pin4_signal_select == SEL_1
      |=> general_pin_4_out == $past(all_lock))
    else $error("lock AND not on pin");

  AST_PORT_REMOTE0: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && !pin4_source_group[2] && pin4_signal_select == SEL_0
      |=> general_pin_4_out == $past(port_sel.remote_pins[0]))
    else $error("remote pin 0 not on pin");

  AST_PORT_REMOTE2: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && !pin4_source_group[2] && pin4_signal_select == SEL_1
      |=> general_pin_4_out == $past(port_sel.remote_pins[2]))
    else $error("remote pin 2 not on pin");

  AST_PORT_REMOTE3: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && !pin4_source_group[2] && pin4_signal_select == SEL_3
      |=> general_pin_4_out == $past(port_sel.remote_pins[3]))
    else $error("remote pin 3 not on pin");

  AST_PORT_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && !pin4_source_group[2] && pin4_signal_select == SEL_5
      |=> general_pin_4_out == $past(port_sel.pass))
    else $error("port pass not on pin");

  AST_PORT_FRAME: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && !pin4_source_group[2] && pin4_signal_select == SEL_6
      |=> general_pin_4_out == $past(port_sel.frame_valid))
    else $error("port frame valid not on pin");

  AST_PORT_LINE: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && !pin4_source_group[2] && pin4_signal_select == SEL_7
      |=> general_pin_4_out == $past(port_sel.line_valid))
    else $error("port line valid not on pin");

  AST_ALL_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && pin4_source_group == SRC_STATUS && pin4_signal_select == SEL_3
      |=> general_pin_4_out == $past(all_pass))
    else $error("pass AND not on pin");

  AST_TX_PASS_AND: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && pin4_source_group == SRC_TX && pin4_signal_select == SEL_0
      |=> general_pin_4_out == $past(sel_pass_and))
    else $error("selected pass AND not on pin");

  AST_TX_PASS_OR: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && pin4_source_group == SRC_TX && pin4_signal_select == SEL_1
      |=> general_pin_4_out == $past(sel_pass_or))
    else $error("selected pass OR not on pin");

  AST_TX_FRAME: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && pin4_source_group == SRC_TX && pin4_signal_select == SEL_2
      |=> general_pin_4_out == $past(tx_status.frame_valid))
    else $error("transmit frame valid not on pin");

  AST_TX_LINE: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && pin4_source_group == SRC_TX && pin4_signal_select == SEL_3
      |=> general_pin_4_out == $past(tx_status.line_valid))
    else $error("transmit line valid not on pin");

  AST_TX_SYNC: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_drive_enable && pin4_source_group == SRC_TX && pin4_signal_select == SEL_4
      |=> general_pin_4_out == $past(tx_status.synchronized))
    else $error("synchronized indication not on pin");

  AST_RESERVED_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pin4_source_group[2] && pin4_source_group != SRC_STATUS
      && pin4_source_group != SRC_TX |=> !general_pin_4_out)
    else $error("reserved source drove the pin high");

  AST_BUS_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus response not ready and okay");

  AST_FROZEN: assert property (@(posedge hclk) disable iff (!hresetn)
    !clk_en |=> $stable(pin4_output_control) && $stable(general_pin_4_oe_n)
      && $stable(general_pin_4_out))
    else $error("state moved while clock enable was low");

endmodule
`default_nettype wire

// >>> hdl/pin_mux_pkg.sv
package pin_mux_pkg;
  localparam logic [7:0] PIN4_CTRL_ADDR = 8'h14;
  localparam logic [7:0] PIN4_CTRL_RESET = 8'h00;
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 5;
  localparam int SRC_HI = 4;
  localparam int SRC_LO = 2;
  localparam int VAL_BIT = 1;
  localparam int EN_BIT = 0;
  localparam int NUM_PORTS = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] SRC_STATUS = 3'h4;
  localparam logic [2:0] SRC_TX = 3'h6;
  localparam logic [2:0] SEL_0 = 3'h0;
  localparam logic [2:0] SEL_1 = 3'h1;
  localparam logic [2:0] SEL_2 = 3'h2;
  localparam logic [2:0] SEL_3 = 3'h3;
  localparam logic [2:0] SEL_4 = 3'h4;
  localparam logic [2:0] SEL_5 = 3'h5;
  localparam logic [2:0] SEL_6 = 3'h6;
  localparam logic [2:0] SEL_7 = 3'h7;

  // Per receive port status as seen by the mux.
  typedef struct packed {
    logic [3:0] remote_pins;
    logic lock;
    logic pass;
    logic frame_valid;
    logic line_valid;
    logic enabled;
    logic selected;
  } rx_status_t;

  // Transmit side status.
  typedef struct packed {
    logic frame_valid;
    logic line_valid;
    logic synchronized;
    logic irq;
  } tx_status_t;
endpackage

// >>> dv/pin_load.sv
`timescale 1ns/1ps
`default_nettype none
// Board load on the pin; a pull-down holds the line low whenever the hub releases it.
module pin_load (
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_level
);
  assign pin_level = pin_oe_n ? 1'b0 : pin_out;
endmodule
`default_nettype wire

// >>> dv/gpio_pin_output_mux_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_output_mux_tb_top;
  import pin_mux_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic clk_en = 1'b1;
  localparam logic [31:0] ADDR = {24'h0, PIN4_CTRL_ADDR};
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pin_out, pin_oe_n, pin_level;
  rx_status_t [3:0] rx = '0;
  tx_status_t tx = '0;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  initial forever #20 hclk = ~hclk;
  gpio_pin_output_mux i_gpio_pin_output_mux (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_status(rx), .tx_status(tx), .general_pin_4_out(pin_out),
    .general_pin_4_oe_n(pin_oe_n));
  pin_load i_pin_load (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Single AHB transfer; entered just after a rising edge, waits on hready in both phases.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask
  function automatic logic exp_pin(input logic [7:0] c, input rx_status_t [3:0] r,
                                   input tx_status_t t);
    logic [7:0] pv, sv, tv;
    logic al, ol, ap, as, os;
    rx_status_t p;
    p = r[c[3:2]];
    al = 1'b1;
    ol = 1'b0;
    ap = 1'b1;
    as = 1'b1;
    os = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (r[i].enabled) begin
        al &= r[i].lock;
        ol |= r[i].lock;
        ap &= r[i].pass;
      end
      if (r[i].selected) begin
        as &= r[i].pass;
        os |= r[i].pass;
      end
    end
    pv = {p.line_valid, p.frame_valid, p.pass, p.lock, p.remote_pins[3], 1'b0,
          p.remote_pins[2], p.remote_pins[0]};
    sv = {4'h0, ap, ol, al, c[1]};
    tv = {2'h0, t.irq, t.synchronized, t.line_valid, t.frame_valid, os, as};
    if (!c[0]) return 1'b0;
    if (!c[4]) return pv[c[7:5]];
    if (c[4:2] == SRC_STATUS) return sv[c[7:5]];
    if (c[4:2] == SRC_TX) return tv[c[7:5]];
    return 1'b0;
  endfunction
  task automatic t_reset;
    logic [31:0] d;
    bus(1'b0, ADDR, 32'h0, d);
    cmp("ctl reset", {24'h0, PIN4_CTRL_RESET}, d);
    cmp("oe_n reset", 32'h1, {31'h0, pin_oe_n});
    cmp("pin reset", 32'h0, {31'h0, pin_level});
  endtask
  task automatic t_regs;
    logic [31:0] d;
    bus(1'b1, ADDR, 32'hFF, d);
    bus(1'b1, 32'h18, 32'h55, d);
    bus(1'b0, 32'h18, 32'h0, d);
    cmp("unmapped", 32'h0, d);
    bus(1'b0, ADDR, 32'h0, d);
    cmp("ctl rw", 32'hFF, d);
  endtask
  // Every control byte against one status pattern; the pin is judged through the board load.
  // The pin is sampled on the falling edge, well away from the edge that launches it.
  task automatic t_mux(input logic [39:0] pat, input logic [3:0] tp);
    logic [31:0] d, e, p;
    rx <= pat;
    tx <= tp;
    for (int i = 0; i < 256; i++) begin
      bus(1'b1, ADDR, i, d);
      @(posedge hclk);
      @(negedge hclk);
      e = {31'h0, exp_pin(i[7:0], pat, tp)};
      p = {31'h0, pin_level};
      if (!i[0]) begin
        cmp("pin off", e, p);
      end else if (!i[4]) begin
        cmp("pin port", e, p);
      end else if (i[4:2] == SRC_STATUS) begin
        cmp("pin status", e, p);
      end else if (i[4:2] == SRC_TX) begin
        cmp("pin tx", e, p);
      end else begin
        cmp("pin reserved", e, p);
      end
      cmp("oe_n", {31'h0, ~i[0]}, {31'h0, pin_oe_n});
      @(posedge hclk);
    end
  endtask
  // A write made while the clock enable is low is lost, and the pin keeps its level.
  task automatic t_freeze;
    logic [31:0] d;
    bus(1'b1, ADDR, {24'h0, SEL_0, SRC_STATUS, 1'b1, 1'b1}, d);
    @(posedge hclk);
    clk_en <= 1'b0;
    bus(1'b1, ADDR, 32'h0, d);
    clk_en <= 1'b1;
    @(posedge hclk);
    @(negedge hclk);
    cmp("pin frozen", 32'h1, {31'h0, pin_level});
    cmp("oe_n frozen", 32'h0, {31'h0, pin_oe_n});
    @(posedge hclk);
    bus(1'b0, ADDR, 32'h0, d);
    cmp("ctl frozen", {24'h0, SEL_0, SRC_STATUS, 1'b1, 1'b1}, d);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_regs();
    t_mux(40'h96A53C3A5E, 4'h5);
    t_mux(40'h695AC3C5A1, 4'hA);
    t_mux(40'hA557AC30F3, 4'h6);
    t_freeze();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
